// ---- inc/clock_select_map.svh ----
// Register offsets, field positions, reset values and timing counts of the clock selector.
// Assumes a byte-wide register port where byte address is four times the register index.
//
// Function
// - Output enable drives peripheral clock onto pin.
// - Select field picks fast, slow, crystal, external.
// - Ratio codes 0-5 divide by 2..64.
// - Ratio codes 8-C divide by 6..48.
// - Prescaler off: peripheral clock undivided, pin at half main rate.
// - Ratio writes at run time take effect.
// - Lock freezes select, prescaler, main calibration.
// - Lock stays set until hardware reset.
// - Stable flags only for requested sources.
// - Status bits hold five source stable flags.
// - Switching flag set until new source stable.
// - Standby-running fast oscillator gates open after two.
// - Frequency field codes select 1 to 24 MHz.
// - Auto-tune uses crystal, crystal must run.
// - Protected writes need unlock key within four.
// - Trim is sign-extended, frozen during auto-tune.
// - Auto-tune corrects errors, pauses 64 ms when tuned.
`ifndef CLOCK_SELECT_MAP_SVH
`define CLOCK_SELECT_MAP_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_SOURCE_CONTROL 4'h0
`define IDX_DIVIDER_CTRL 4'h1
`define IDX_SETTING_LOCK 4'h2
`define IDX_SOURCE_STATUS 4'h3
`define IDX_FAST_OSC_CONTROL 4'h8
`define IDX_FAST_OSC_TRIM 4'h9

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define POS_PIN_OUTPUT 7
`define POS_PRESCALE_ON 0
`define POS_RATIO_LSB 1
`define POS_KEEP_RUNNING 7
`define POS_FREQ_LSB 2
`define POS_AUTO_TRIM 0
`define POS_TRIM_SIGN 5
`define RST_SOURCE_CONTROL 8'h00
`define RST_DIVIDER_CTRL 8'h00
`define RST_FAST_OSC_CONTROL 8'h0c
`define RST_FAST_OSC_TRIM 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_HZ 50000000
`define UNLOCK_WINDOW_CYCLES 3'h4
`define GATE_OPEN_CYCLES 2'h2
`define TUNE_PAUSE_MS 64
`define TUNE_PAUSE_CYCLES (`TUNE_PAUSE_MS * (`CLOCK_HZ / 1000))
`define TUNE_COUNT_LOW 10'h3d0
`define TUNE_COUNT_HIGH 10'h3d1

`endif

// ---- inc/clock_select_pkg.sv ----
// Types shared by the clock selector modules.
// Assumes the constants of clock_select_map.svh are included where needed.
`default_nettype none
package clock_select_pkg;
    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_SLOW = 2'h1,
        SRC_CRYSTAL = 2'h2,
        SRC_EXTERNAL = 2'h3
    } source_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b01,
        SW_PENDING = 2'b10
    } switch_state_t;

    typedef enum logic [1:0] {
        TUNE_MEASURE = 2'b01,
        TUNE_PAUSE = 2'b10
    } tune_state_t;
endpackage
`default_nettype wire

// ---- rtl/prescale_divider.sv ----
// Peripheral clock divider: one-cycle enable per period and a square wave for the pin.
// Assumes the division count is stable or changes only between register writes.
`default_nettype none
module prescale_divider #(
    parameter int WIDTH = 7
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] ratio,
    output logic tick,
    output logic wave
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] half;
    logic wrap;

    assign wrap = (count >= ratio - 1'b1);
    assign half = ratio >> 1;

    // A count already past a shortened ratio restarts at once, so the new rate follows the write.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
        end
    end

    // Undivided, the pin can only toggle, so it shows half the main rate.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
            wave <= 1'b0;
        end else begin
            tick <= wrap;
            wave <= (ratio == 7'h01) ? ~wave : (count < half);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/auto_trim_engine.sv ----
// Auto-tune loop: counts 1 MHz edges per reference period and steps the trim.
// Assumes edge pulses arrive already synchronised to the clock.
`include "clock_select_map.svh"
`default_nettype none
module auto_trim_engine #(
    parameter int PAUSE_CYCLES = `TUNE_PAUSE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic ref_ok,
    input wire logic ref_edge,
    input wire logic osc_edge,
    input wire logic [7:0] start_value,
    output logic [7:0] trim
);
    clock_select_pkg::tune_state_t state;
    logic [9:0] osc_count;
    logic [21:0] pause_count;
    logic too_slow;
    logic too_fast;
    logic [7:0] step_up;
    logic [7:0] step_down;

    assign too_slow = osc_count < `TUNE_COUNT_LOW;
    assign too_fast = osc_count > `TUNE_COUNT_HIGH;
    assign step_up = (trim == 8'h1f) ? trim : trim + 8'h01;
    assign step_down = (trim == 8'he0) ? trim : trim - 8'h01;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= clock_select_pkg::TUNE_MEASURE;
            osc_count <= '0;
            pause_count <= '0;
            trim <= 8'h00;
        end else if (!enable || !ref_ok) begin
            state <= clock_select_pkg::TUNE_MEASURE;
            osc_count <= '0;
            trim <= start_value;
        end else begin
            unique case (state)
                clock_select_pkg::TUNE_MEASURE: begin
                    if (ref_edge) begin
                        osc_count <= '0;
                        if (too_slow) begin
                            trim <= step_up;
                        end else if (too_fast) begin
                            trim <= step_down;
                        end else begin
                            state <= clock_select_pkg::TUNE_PAUSE;
                            pause_count <= 22'(PAUSE_CYCLES - 1);
                        end
                    end else if (osc_edge && osc_count != 10'h3ff) begin
                        osc_count <= osc_count + 10'h001;
                    end
                end
                clock_select_pkg::TUNE_PAUSE: begin
                    osc_count <= '0;
                    if (pause_count == '0) begin
                        state <= clock_select_pkg::TUNE_MEASURE;
                    end else begin
                        pause_count <= pause_count - 22'h00_0001;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/main_clock_select_prescale.sv ----
// Main clock selector with prescaler, lock, status and fast oscillator control.
// Assumes peripherals and the CPU share this clock; oscillator ready lines are asynchronous.
//
// Implementation choice: the plain strobed port.
`include "clock_select_map.svh"
`default_nettype none
module main_clock_select_prescale #(
    parameter int PAUSE_CYCLES = `TUNE_PAUSE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic unlock_key_written,
    input wire logic [4:0] periph_request,
    input wire logic [4:0] source_ready,
    input wire logic crystal_ref_pin,
    input wire logic fast_osc_1mhz_pin,
    output logic [7:0] read_data,
    output logic periph_clock_pin_output,
    output logic periph_clock_pin_enable,
    output logic peripheral_clock,
    output logic [1:0] main_source,
    output logic [4:0] source_request,
    output logic fast_osc_run,
    output logic [3:0] fast_osc_freq_select,
    output logic [7:0] fast_osc_trim_value
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync_first;
    logic [6:0] sync_second;
    logic [1:0] edge_prev;
    logic [4:0] ready;
    logic ref_edge;
    logic osc_edge;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_first <= '0;
            sync_second <= '0;
            edge_prev <= '0;
        end else begin
            sync_first <= {fast_osc_1mhz_pin, crystal_ref_pin, source_ready};
            sync_second <= sync_first;
            edge_prev <= sync_second[6:5];
        end
    end

    assign ready = sync_second[4:0];
    assign ref_edge = sync_second[5] & ~edge_prev[0];
    assign osc_edge = sync_second[6] & ~edge_prev[1];

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic pin_output_on;
    logic [1:0] main_source_select;
    logic prescale_on;
    logic [3:0] prescale_ratio;
    logic freeze_select_regs;
    logic keep_running_in_standby;
    logic [3:0] fast_freq;
    logic auto_trim_enable;
    logic [7:0] trim_reg;
    logic [2:0] unlock_window;
    logic [7:0] engine_trim;
    logic auto_prev;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    logic [3:0] index;
    logic aligned;
    logic unlocked;
    logic hit_source;
    logic hit_divider;
    logic hit_lock;
    logic hit_fast_ctrl;
    logic hit_trim;
    logic hit_status;
    logic wr_source;
    logic wr_divider;
    logic wr_lock;
    logic wr_fast_ctrl;
    logic wr_trim;
    logic select_reserved;
    logic main_is_fast;

    assign index = address[5:2];
    assign aligned = (address[1:0] == 2'h0);
    assign unlocked = (unlock_window != 3'h0);
    assign hit_source = aligned && index == `IDX_SOURCE_CONTROL;
    assign hit_divider = aligned && index == `IDX_DIVIDER_CTRL;
    assign hit_lock = aligned && index == `IDX_SETTING_LOCK;
    assign hit_fast_ctrl = aligned && index == `IDX_FAST_OSC_CONTROL;
    assign hit_trim = aligned && index == `IDX_FAST_OSC_TRIM;
    assign hit_status = aligned && index == `IDX_SOURCE_STATUS;
    assign main_is_fast = (main_source == clock_select_pkg::SRC_FAST);
    assign select_reserved = (write_data[3:2] != 2'h0);
    // Refused writes fall through these terms and change no setting, though their strobe still closes the unlock window.
    assign wr_source = write_strobe && hit_source && unlocked && !freeze_select_regs;
    assign wr_divider = write_strobe && hit_divider && unlocked && !freeze_select_regs;
    assign wr_lock = write_strobe && hit_lock && unlocked && !freeze_select_regs;
    assign wr_fast_ctrl = write_strobe && hit_fast_ctrl && unlocked;
    assign wr_trim = write_strobe && hit_trim && !auto_trim_enable
        && !(freeze_select_regs && main_is_fast);

    // The key opens a window of four cycles, closed early by any register write.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            unlock_window <= 3'h0;
        end else if (unlock_key_written) begin
            unlock_window <= `UNLOCK_WINDOW_CYCLES;
        end else if (write_strobe || unlocked) begin
            unlock_window <= write_strobe ? 3'h0 : unlock_window - 3'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_output_on <= 1'(`RST_SOURCE_CONTROL >> `POS_PIN_OUTPUT);
            main_source_select <= 2'h0;
        end else if (wr_source) begin
            pin_output_on <= write_data[`POS_PIN_OUTPUT];
            if (!select_reserved) begin
                main_source_select <= write_data[1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_on <= 1'b0;
            prescale_ratio <= 4'h0;
        end else if (wr_divider) begin
            prescale_on <= write_data[`POS_PRESCALE_ON];
            prescale_ratio <= write_data[`POS_RATIO_LSB +: 4];
        end
    end

    // Only a hardware reset can take the lock down again.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            freeze_select_regs <= 1'b0;
        end else if (wr_lock && write_data[0]) begin
            freeze_select_regs <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keep_running_in_standby <= 1'b0;
            fast_freq <= 4'h3;
            auto_trim_enable <= 1'b0;
        end else if (wr_fast_ctrl) begin
            keep_running_in_standby <= write_data[`POS_KEEP_RUNNING];
            fast_freq <= write_data[`POS_FREQ_LSB +: 4];
            auto_trim_enable <= write_data[`POS_AUTO_TRIM];
        end
    end

    // The trim register takes the tuned value once auto-tune is switched off.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trim_reg <= `RST_FAST_OSC_TRIM;
            auto_prev <= 1'b0;
        end else begin
            auto_prev <= auto_trim_enable;
            if (auto_prev && !auto_trim_enable) begin
                trim_reg <= engine_trim;
            end else if (wr_trim) begin
                trim_reg <= {{3{write_data[`POS_TRIM_SIGN]}}, write_data[4:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Requests, gating and stable flags
    // ----------------------------------------------------------------
    logic [4:0] requested;
    logic [4:0] stable;
    logic [1:0] gate_count;
    logic [3:0] pending_onehot;

    assign pending_onehot = 4'h1 << main_source_select;
    // The active source stays requested during a switch so the old clock never stops.
    assign requested[0] = periph_request[0] || main_is_fast || pending_onehot[0];
    assign requested[1] = periph_request[1] || main_source == clock_select_pkg::SRC_SLOW
        || pending_onehot[1];
    assign requested[2] = periph_request[2] || main_source == clock_select_pkg::SRC_CRYSTAL
        || pending_onehot[2] || auto_trim_enable;
    assign requested[3] = periph_request[3] || main_source == clock_select_pkg::SRC_EXTERNAL
        || pending_onehot[3];
    assign requested[4] = periph_request[4];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_count <= 2'h0;
        end else if (!requested[0]) begin
            gate_count <= 2'h0;
        end else if (ready[0] && gate_count != `GATE_OPEN_CYCLES) begin
            gate_count <= gate_count + 2'h1;
        end
    end

    // A source kept alive only by standby running is not reported as stable.
    assign stable[0] = requested[0] && ready[0] && gate_count == `GATE_OPEN_CYCLES;
    assign stable[4:1] = requested[4:1] & ready[4:1];

    // ----------------------------------------------------------------
    // Source switch
    // ----------------------------------------------------------------
    clock_select_pkg::switch_state_t switch_state;
    logic target_stable;

    assign target_stable = stable[{1'b0, main_source_select}];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            switch_state <= clock_select_pkg::SW_IDLE;
            main_source <= 2'h0;
        end else begin
            unique case (switch_state)
                clock_select_pkg::SW_IDLE: begin
                    if (main_source_select != main_source) begin
                        switch_state <= clock_select_pkg::SW_PENDING;
                    end
                end
                clock_select_pkg::SW_PENDING: begin
                    if (main_source_select == main_source) begin
                        switch_state <= clock_select_pkg::SW_IDLE;
                    end else if (target_stable) begin
                        main_source <= main_source_select;
                        switch_state <= clock_select_pkg::SW_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    logic [6:0] ratio_count;
    logic divider_tick;
    logic divider_wave;

    // Reserved ratio codes fall back to a divide by two.
    always_comb begin
        unique case (prescale_ratio)
            4'h0: ratio_count = 7'h02;
            4'h1: ratio_count = 7'h04;
            4'h2: ratio_count = 7'h08;
            4'h3: ratio_count = 7'h10;
            4'h4: ratio_count = 7'h20;
            4'h5: ratio_count = 7'h40;
            4'h8: ratio_count = 7'h06;
            4'h9: ratio_count = 7'h0a;
            4'ha: ratio_count = 7'h0c;
            4'hb: ratio_count = 7'h18;
            4'hc: ratio_count = 7'h30;
            default: ratio_count = 7'h02;
        endcase
        if (!prescale_on) begin
            ratio_count = 7'h01;
        end
    end

    prescale_divider #(
        .WIDTH(7)
    ) divider (
        .clock(clock),
        .rst(rst),
        .ratio(ratio_count),
        .tick(divider_tick),
        .wave(divider_wave)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            peripheral_clock <= 1'b0;
            periph_clock_pin_output <= 1'b0;
            periph_clock_pin_enable <= 1'b0;
        end else begin
            peripheral_clock <= divider_tick;
            periph_clock_pin_output <= pin_output_on && divider_wave;
            periph_clock_pin_enable <= pin_output_on;
        end
    end

    // ----------------------------------------------------------------
    // Auto-tune and oscillator outputs
    // ----------------------------------------------------------------
    auto_trim_engine #(
        .PAUSE_CYCLES(PAUSE_CYCLES)
    ) tuner (
        .clock(clock),
        .rst(rst),
        .enable(auto_trim_enable),
        .ref_ok(stable[2]),
        .ref_edge(ref_edge),
        .osc_edge(osc_edge),
        .start_value(trim_reg),
        .trim(engine_trim)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            source_request <= 5'h00;
            fast_osc_run <= 1'b0;
            fast_osc_freq_select <= 4'h3;
            fast_osc_trim_value <= `RST_FAST_OSC_TRIM;
        end else begin
            source_request <= requested;
            fast_osc_run <= requested[0] || keep_running_in_standby;
            fast_osc_freq_select <= fast_freq;
            fast_osc_trim_value <= auto_trim_enable ? engine_trim : trim_reg;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] read_mux;
    logic switching;

    assign switching = (switch_state == clock_select_pkg::SW_PENDING);
    assign read_mux = hit_source ? {pin_output_on, 5'h00, main_source_select} :
        hit_divider ? {3'h0, prescale_ratio, prescale_on} :
        hit_lock ? {7'h00, freeze_select_regs} :
        hit_status ? {2'h0, stable, switching} :
        hit_fast_ctrl ? {keep_running_in_standby, 1'b0, fast_freq, 1'b0, auto_trim_enable} :
        hit_trim ? trim_reg : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_data <= 8'h00;
        end else begin
            read_data <= read_strobe ? read_mux : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- tb/clock_select_properties.sv ----
// Checker for the clock selector: timing relations seen at its ports.
// Assumes one clock domain with an active-high asynchronous reset.
`default_nettype none
module clock_select_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic [7:0] read_data,
    input wire logic periph_clock_pin_output,
    input wire logic periph_clock_pin_enable,
    input wire logic [1:0] main_source,
    input wire logic [4:0] source_request,
    input wire logic [4:0] source_ready,
    input wire logic [4:0] periph_request,
    input wire logic fast_osc_run,
    input wire logic [3:0] fast_osc_freq_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 8'h00)
        else $error("read data outside a read");
    a_pin_held_low: assert property (!periph_clock_pin_enable
        && !$past(periph_clock_pin_enable) |-> !periph_clock_pin_output)
        else $error("clock pin active while disabled");
    a_switch_after_ready: assert property ($changed(main_source)
        |-> (($past(source_ready, 3) >> main_source) & 5'h01) != 5'h00)
        else $error("switched to a source not ready");
    a_switch_target_requested: assert property ($changed(main_source)
        |-> source_request[main_source])
        else $error("main source not requested");
    a_fast_run_request: assert property (source_request[0] |-> ##[0:1] fast_osc_run)
        else $error("fast oscillator not running");
    a_reset_defaults: assert property ($fell(rst)
        |-> fast_osc_freq_select == 4'h3 && main_source == 2'h0)
        else $error("wrong values after reset");
    a_freq_needs_write: assert property ($changed(fast_osc_freq_select)
        |-> $past(write_strobe) || $past(write_strobe, 2))
        else $error("frequency changed without a write");
    // The request register is cleared by reset, so the first edge after release is skipped.
    a_periph_request_seen: assert property (!$past(rst)
        |-> ($past(periph_request, 2) & $past(periph_request) & periph_request
        & ~source_request) == 5'h00)
        else $error("peripheral request not passed on");
    c_switch: cover property ($changed(main_source));
    c_pin: cover property (periph_clock_pin_output);
    c_read: cover property ($past(read_strobe) && read_data != 8'h00);
endmodule
bind main_clock_select_prescale clock_select_properties chk (.*);
`default_nettype wire

// ---- tb/osc_model.sv ----
// Oscillator stand-in: each source settles some cycles after it is requested.
// Assumes the selector's request lines; the reference pins run free.
`default_nettype none
module osc_model (
    input wire logic clock,
    input wire logic [4:0] source_request,
    output logic [4:0] source_ready,
    output logic crystal_ref_pin,
    output logic fast_osc_1mhz_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int age[5] = '{default: 0};
    int ph = 0;
    initial begin
        source_ready = 5'h00;
        crystal_ref_pin = 1'b0;
        fast_osc_1mhz_pin = 1'b0;
    end
    // Later sources settle slower, so a switch is seen pending for a while.
    always @(posedge clock) begin
        ph <= ph + 1;
        fast_osc_1mhz_pin <= (ph / 25) % 2 == 1;
        crystal_ref_pin <= (ph / 24414) % 2 == 1;
        for (int i = 0; i < 5; i++) begin
            age[i] <= source_request[i] ? age[i] + 1 : 0;
            source_ready[i] <= source_request[i] && age[i] >= 3 + 6 * i;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_main_clock_select_prescale.sv ----
// Bench for the clock selector: register port tasks and scripted checks.
// Assumes the oscillator stand-in answers the source requests.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_main_clock_select_prescale;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic [7:0] write_data = 8'h00, read_data, fast_osc_trim_value;
    logic write_strobe = 1'b0, read_strobe = 1'b0, unlock_key_written = 1'b0;
    logic [4:0] periph_request = 5'h00, source_ready, source_request;
    logic crystal_ref_pin, fast_osc_1mhz_pin, periph_clock_pin_output;
    logic periph_clock_pin_enable, peripheral_clock, fast_osc_run;
    logic [1:0] main_source;
    logic [3:0] fast_osc_freq_select;
    int bad_count = 0, n_compared = 0, cycles = 0, n;
    int divs[16] = '{2, 4, 8, 16, 32, 64, 2, 2, 6, 10, 12, 24, 48, 2, 2, 2};
    main_clock_select_prescale #(.PAUSE_CYCLES(50)) DUT (.*);
    osc_model partner (.*);
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 12000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A gap above zero sends the key first, then writes that many cycles later.
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input int gap);
        if (gap > 0) begin
            unlock_key_written <= 1'b1;
            @(posedge clock);
            unlock_key_written <= 1'b0;
            repeat (gap - 1) @(posedge clock);
        end
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 `CHK(read_data, e)
        @(posedge clock);
    endtask
    // The first gaps after a ratio change may be irregular, so the third is judged.
    task automatic period(input int e);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (peripheral_clock !== 1'b1 && n < 100);
        end
        `CHK(n, e)
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        periph_request <= 5'h10;
        rd(6'h20, 8'h0c);
        rd(6'h05, 8'h00);
        wr(6'h04, 8'h0b, 0);
        wr(6'h04, 8'h0b, 5);
        rd(6'h04, 8'h00);
        for (int c = 0; c < 13; c++) begin
            wr(6'h04, 8'((c << 1) | 1), 4);
            rd(6'h04, 8'((c << 1) | 1));
            period(divs[c]);
        end
        wr(6'h04, 8'h18, 1);
        period(1);
        for (int k = 0; k < 2; k++) begin
            wr(6'h00, k ? 8'h00 : 8'h84, 1);
            rd(6'h00, k ? 8'h00 : 8'h80);
            n = 0;
            repeat (16) begin
                @(posedge clock);
                n += int'(periph_clock_pin_output === 1'b1);
            end
            `CHK(periph_clock_pin_enable, 1'(!k))
            `CHK(n > 0, k == 0)
        end
        for (int k = 1; k <= 4; k++) begin
            wr(6'h00, 8'(k % 4), 1);
            @(posedge clock);
            rd(6'h0c, 8'h21 | (8'h02 << ((k - 1) % 4)));
            n = 0;
            while (main_source !== 2'(k % 4) && n < 200) begin
                @(posedge clock);
                n++;
            end
            `CHK(main_source, 2'(k % 4))
            repeat (4) @(posedge clock);
            rd(6'h0c, 8'h20 | (8'h02 << (k % 4)));
        end
        wr(6'h20, 8'h24, 1);
        // The field lands at the write edge and the output register one edge later.
        repeat (2) @(posedge clock);
        #1 `CHK(fast_osc_freq_select, 4'h9)
        @(posedge clock);
        wr(6'h24, 8'h20, 0);
        rd(6'h24, 8'he0);
        wr(6'h24, 8'hdf, 0);
        rd(6'h24, 8'h1f);
        `CHK(fast_osc_trim_value, 8'h1f)
        wr(6'h08, 8'h01, 1);
        wr(6'h04, 8'h03, 1);
        rd(6'h04, 8'h18);
        wr(6'h24, 8'h05, 0);
        rd(6'h24, 8'h1f);
        wr(6'h08, 8'h00, 1);
        rd(6'h08, 8'h01);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(6'h08, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
